// [rtl/ppi_port_pins.sv]
// ppi_port_pins: port a / port b pin logic, pulls, slow edges, external
// interrupt combine and reset pin roles, with an apb register slave.
// assumes port pin inputs synchronous to I_REF_CLK; irq and reset pins are
// asynchronous and synchronised here. pin wires are resolved outside.
`timescale 1ns/100ps
`default_nettype none

// Function
// (R1) reset pin low restores start-up state
// (R2) low-voltage reset drives reset pin low
// (R3) option: falling edge or edge-and-level irq
// (R4) option: keypad lines or-ed, inverted, into irq
// (R5) keypad lines share irq sensitivity option
// (R6) top port a line: own falling-edge interrupt
// (R7) port a lines inputs after reset
// (R8) port b lines inputs after reset
// (R9) top two a open-drain, lower six push-pull
// (R10) a pull-ups always, pull-downs input only
// (R11) pulls per-line enabled, present by option
// (R12) slow edge on top a lines when outputs
// (R13) b one/two open-drain, others push-pull
// (R14) b pull-ups always, pull-downs input only
// (R15) b line one slow edge when output
// (R16) b line two one cycle late when slow
// (R17) software writes b one/two equal together
// (R18) reduced package hides b lines two-five
// (R19) data read: pin if input, latch if output
// (R20) irq and reset pins synchronised twice
module ppi_port_pins #(
  parameter bit KEYPAD_EN = 1'b1,
  parameter bit LEVEL_TRIG = 1'b0,
  parameter bit PULL_PRESENT = 1'b1,
  parameter bit REDUCED_PKG = 1'b0
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire ppi_pkg::ppi_apb_req_s I_APB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [ppi_pkg::PA_W-1:0] I_PA_IN,
  output logic [ppi_pkg::PA_W-1:0] O_PA_OUT,
  output logic [ppi_pkg::PA_W-1:0] O_PA_OEN_N,
  output logic [ppi_pkg::PA_W-1:0] O_PA_PULL,
  output logic [1:0] O_PA_SLOW,
  input wire logic [ppi_pkg::PB_W-1:0] I_PB_IN,
  output logic [ppi_pkg::PB_W-1:0] O_PB_OUT,
  output logic [ppi_pkg::PB_W-1:0] O_PB_OEN_N,
  output logic [ppi_pkg::PB_W-1:0] O_PB_PULL,
  output logic O_PB_SLOW,
  input wire logic I_IRQ_N,
  output logic O_IRQ_REQ,
  output logic O_TOP_IRQ_REQ,
  input wire logic I_RESET_PIN_N,
  input wire logic I_LOW_VOLTAGE_DETECTOR_RESET,
  output logic O_RESET_PIN_OUT,
  output logic O_RESET_PIN_OEN_N,
  output logic O_CORE_RESET_N
);
  import ppi_pkg::*;

  // ==========================================================
  // reset pin and irq pin synchronisers
  logic rst_s1_ff, rst_s2_ff, irq_s1_ff, irq_s2_ff, soft_rst;
  logic rst_drive_ff;

  // first stages are read only by the second stages
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
      irq_s1_ff <= 1'b1;
      irq_s2_ff <= 1'b1;
    end else begin
      rst_s1_ff <= I_RESET_PIN_N; // see (R20)
      rst_s2_ff <= rst_s1_ff;
      irq_s1_ff <= I_IRQ_N; // see (R20)
      irq_s2_ff <= irq_s1_ff;
    end
  end

  // a low reset pin holds every control register at its start value
  assign soft_rst = ~rst_s2_ff; // see (R1)

  // lvd drives the pin low; the pin's own low then resets us through the sync
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_drive_ff <= 1'b0;
    end else begin
      rst_drive_ff <= I_LOW_VOLTAGE_DETECTOR_RESET; // see (R2)
    end
  end

  assign O_RESET_PIN_OUT = 1'b0;
  assign O_RESET_PIN_OEN_N = ~rst_drive_ff;
  assign O_CORE_RESET_N = rst_s2_ff;

  // ==========================================================
  // apb decode
  logic setup, wr_acc;
  logic [ADDR_W-1:0] idx;
  logic [31:0] rd_data, prdata_ff;
  logic mapped, pslverr_ff;
  assign setup = I_APB.psel & ~I_APB.penable;
  assign wr_acc = I_APB.psel & I_APB.penable & I_APB.pwrite & ~pslverr_ff;
  assign idx = {2'b00, I_APB.paddr[ADDR_W-1:2]};
  assign mapped = (I_APB.paddr[1:0] == 2'b00) &&
                  (idx == IDX_PA_DATA || idx == IDX_PB_DATA || idx == IDX_PA_DIR ||
                   idx == IDX_PB_DIR || idx == IDX_IRQ_CSR || idx == IDX_PA_PULL ||
                   idx == IDX_PB_PULL);

  // ==========================================================
  // control registers
  logic [7:0] pa_lat_ff, pa_dir_ff, pa_pull_ff;
  logic [5:0] pb_lat_ff, pb_dir_ff, pb_pull_ff;
  logic slow_ff, irq_en_ff, top_en_ff, irq_flag_ff, top_flag_ff;

  // data latches
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pa_lat_ff <= PA_RST;
      pb_lat_ff <= PB_RST;
    end else if (soft_rst) begin
      pa_lat_ff <= PA_RST;
      pb_lat_ff <= PB_RST;
    end else if (wr_acc && idx == IDX_PA_DATA) begin
      pa_lat_ff <= I_APB.pwdata[7:0];
    end else if (wr_acc && idx == IDX_PB_DATA) begin
      pb_lat_ff <= I_APB.pwdata[5:0]; // equal bits 1/2 are software's duty, see (R17)
    end
  end

  // direction and slow-edge enable; all lines inputs after any reset
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pa_dir_ff <= PA_RST;
      pb_dir_ff <= PB_RST;
      slow_ff <= 1'b0;
    end else if (soft_rst) begin
      pa_dir_ff <= PA_RST; // see (R7)
      pb_dir_ff <= PB_RST; // see (R8)
      slow_ff <= 1'b0;
    end else if (wr_acc && idx == IDX_PA_DIR) begin
      pa_dir_ff <= I_APB.pwdata[7:0];
    end else if (wr_acc && idx == IDX_PB_DIR) begin
      pb_dir_ff <= I_APB.pwdata[5:0];
      slow_ff <= I_APB.pwdata[PB_SLOW_BIT];
    end
  end

  // per-line pull enables
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pa_pull_ff <= PA_RST;
      pb_pull_ff <= PB_RST;
    end else if (soft_rst) begin
      pa_pull_ff <= PA_RST;
      pb_pull_ff <= PB_RST;
    end else if (wr_acc && idx == IDX_PA_PULL) begin
      pa_pull_ff <= I_APB.pwdata[7:0]; // see (R11)
    end else if (wr_acc && idx == IDX_PB_PULL) begin
      pb_pull_ff <= I_APB.pwdata[5:0]; // see (R11)
    end
  end

  // ==========================================================
  // interrupt sensing
  logic irq_act, act_prev_ff, top_prev_ff, irq_set, top_set;
  logic csr_wr, irq_clr, top_clr;
  // keypad lines act inverted: a high line looks like a low irq pin
  assign irq_act = ~irq_s2_ff | (KEYPAD_EN & (|I_PA_IN[3:0])); // see (R4)
  // one sensitivity choice covers pin and keypad lines alike
  assign irq_set = LEVEL_TRIG ? irq_act : (irq_act & ~act_prev_ff); // see (R3) (R5)
  assign top_set = ~I_PA_IN[7] & top_prev_ff; // see (R6)
  assign csr_wr = wr_acc && idx == IDX_IRQ_CSR;
  assign irq_clr = csr_wr & I_APB.pwdata[CSR_IRQ_CLR_BIT];
  assign top_clr = csr_wr & I_APB.pwdata[CSR_TOP_CLR_BIT];

  // previous-level history for edge detection
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      act_prev_ff <= 1'b0;
      top_prev_ff <= 1'b0;
    end else begin
      act_prev_ff <= irq_act;
      top_prev_ff <= I_PA_IN[7];
    end
  end

  // enables and sticky flags; a set in the clear cycle wins
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      irq_en_ff <= 1'b0;
      top_en_ff <= 1'b0;
      irq_flag_ff <= 1'b0;
      top_flag_ff <= 1'b0;
    end else if (soft_rst) begin
      irq_en_ff <= 1'b0;
      top_en_ff <= 1'b0;
      irq_flag_ff <= 1'b0;
      top_flag_ff <= 1'b0;
    end else begin
      if (csr_wr) begin
        irq_en_ff <= I_APB.pwdata[CSR_IRQ_EN_BIT];
        top_en_ff <= I_APB.pwdata[CSR_TOP_EN_BIT];
      end
      irq_flag_ff <= irq_set | (irq_flag_ff & ~irq_clr); // see (R3)
      top_flag_ff <= top_set | (top_flag_ff & ~top_clr); // see (R6)
    end
  end

  assign O_IRQ_REQ = irq_flag_ff & irq_en_ff;
  assign O_TOP_IRQ_REQ = top_flag_ff & top_en_ff;

  // ==========================================================
  // pin drive: open-drain lines only pull low, others push-pull
  logic [7:0] pa_od_mask;
  logic [5:0] pb_od_mask, pb_hide_mask, pb_lat_eff;
  logic pb2_dly_ff;
  assign pa_od_mask = 8'hC0; // see (R9)
  assign pb_od_mask = 6'h06; // see (R13)
  // reduced package leaves lines two to five unbonded
  assign pb_hide_mask = REDUCED_PKG ? 6'h3C : 6'h00; // see (R18)

  // slow edges retime line two by one cycle so two sinks stagger on the pin
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pb2_dly_ff <= 1'b0;
    end else begin
      pb2_dly_ff <= pb_lat_ff[2];
    end
  end
  assign pb_lat_eff = {pb_lat_ff[5:3], slow_ff ? pb2_dly_ff : pb_lat_ff[2],
                       pb_lat_ff[1:0]}; // see (R16)

  // registered pin outputs
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PA_OUT <= PA_RST;
      O_PA_OEN_N <= 8'hFF;
      O_PB_OUT <= PB_RST;
      O_PB_OEN_N <= 6'h3F;
      O_PA_SLOW <= 2'b00;
      O_PB_SLOW <= 1'b0;
    end else begin
      O_PA_OUT <= pa_lat_ff & ~pa_od_mask; // see (R9)
      O_PA_OEN_N <= ~(pa_dir_ff & (pa_od_mask & ~pa_lat_ff | ~pa_od_mask)); // see (R9)
      O_PB_OUT <= pb_lat_eff & ~pb_od_mask & ~pb_hide_mask; // see (R13)
      O_PB_OEN_N <= ~(pb_dir_ff & ~pb_hide_mask &
                      (pb_od_mask & ~pb_lat_eff | ~pb_od_mask)); // see (R13) (R18)
      O_PA_SLOW <= {2{slow_ff}} & pa_dir_ff[7:6]; // see (R12)
      O_PB_SLOW <= slow_ff & pb_dir_ff[1]; // see (R15)
    end
  end

  // pulls: pull-ups hold in both directions, pull-downs only on inputs
  assign O_PA_PULL = PULL_PRESENT ?
    (pa_pull_ff & (pa_od_mask | ~pa_dir_ff)) : 8'h00; // see (R10) (R11)
  assign O_PB_PULL = PULL_PRESENT ?
    (pb_pull_ff & ~pb_hide_mask & (pb_od_mask | ~pb_dir_ff)) : 6'h00; // see (R14) (R18)

  // ==========================================================
  // read mux; on the reduced package line two reads the shared pin
  logic [5:0] pb_pin;
  assign pb_pin = REDUCED_PKG ? {3'b000, I_PB_IN[1], I_PB_IN[1:0]} : I_PB_IN;

  always_comb begin
    rd_data = RD_ZERO;
    unique case (idx)
      IDX_PA_DATA: rd_data[7:0] = (pa_dir_ff & pa_lat_ff) | (~pa_dir_ff & I_PA_IN); // see (R19)
      IDX_PB_DATA: rd_data[5:0] = (pb_dir_ff & pb_lat_ff) | (~pb_dir_ff & pb_pin); // see (R19)
      IDX_PA_DIR: rd_data[7:0] = pa_dir_ff;
      IDX_PB_DIR: rd_data[7:0] = {slow_ff, 1'b0, pb_dir_ff};
      IDX_IRQ_CSR: rd_data[7:0] = {irq_en_ff, top_en_ff, 2'b00, irq_flag_ff, top_flag_ff, 2'b00};
      IDX_PA_PULL: rd_data[7:0] = pa_pull_ff;
      IDX_PB_PULL: rd_data[5:0] = pb_pull_ff;
      default: rd_data = RD_ZERO;
    endcase
  end

  // read data and error are caught in the setup cycle: one wait-free access
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      prdata_ff <= RD_ZERO;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= mapped ? rd_data : RD_ZERO;
      pslverr_ff <= ~mapped;
    end
  end

  assign O_PRDATA = prdata_ff;
  assign O_PREADY = I_APB.psel & I_APB.penable;
  assign O_PSLVERR = O_PREADY & pslverr_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);

  sequence pin_low_held;
    !I_RESET_PIN_N [*3];
  endsequence

  dir_after_reset_a: assert property (pin_low_held |=> pa_dir_ff == 8'h00 && pb_dir_ff == 6'h00) // see (R7) (R8)
    else $error("direction not cleared by reset pin");
  reset_pin_sync_a: assert property (pin_low_held |=> !O_CORE_RESET_N) // see (R1) (R20)
    else $error("core reset not asserted after pin low");
  lvd_drive_a: assert property (I_LOW_VOLTAGE_DETECTOR_RESET |=> !O_RESET_PIN_OEN_N) // see (R2)
    else $error("reset pin not driven on lvd");
  irq_edge_set_a: assert property (irq_act && !act_prev_ff && !soft_rst |=> irq_flag_ff) // see (R3)
    else $error("irq edge not flagged");
  irq_level_a: assert property (LEVEL_TRIG && irq_act && !soft_rst |=> irq_flag_ff) // see (R3) (R5)
    else $error("irq level not flagged");
  keypad_or_a: assert property (KEYPAD_EN && $rose(I_PA_IN[0]) && !act_prev_ff // see (R4)
                                && !soft_rst |=> irq_flag_ff)
    else $error("keypad line not or-ed into irq");
  top_fall_a: assert property ($fell(I_PA_IN[7]) && !soft_rst |=> top_flag_ff) // see (R6)
    else $error("top line fall not flagged");
  od_drive_a: assert property (pa_dir_ff[7] && !pa_lat_ff[7] |=> !O_PA_OEN_N[7] && !O_PA_OUT[7]) // see (R9)
    else $error("open-drain line not sinking");
  // each port's pull-down follows its own direction bit
  pulldown_dir_a: assert property ((pa_dir_ff[0] |-> !O_PA_PULL[0]) and // see (R10) (R14)
                                   (pb_dir_ff[0] |-> !O_PB_PULL[0]))
    else $error("pull-down active on output");
  pb2_late_a: assert property (slow_ff && $stable(slow_ff) && pb_dir_ff[2] // see (R16)
                               && $stable(pb_dir_ff[2]) && !REDUCED_PKG
                               |=> O_PB_OEN_N[2] == $past(pb_lat_ff[2], 2))
    else $error("line two not one cycle late");
  slow_out_a: assert property (slow_ff && pa_dir_ff[6] |=> O_PA_SLOW[0]) // see (R12)
    else $error("slow edge missing on output line");
  hidden_lines_a: assert property (REDUCED_PKG |-> O_PB_OEN_N[5:2] == 4'hF) // see (R18)
    else $error("unbonded line driven");

endmodule // ppi_port_pins

`default_nettype wire

// [rtl/ppi_pkg.sv]
// ppi_pkg: register indices, field positions, reset values and bus carrier
// for the port pin and interrupt combine block.
// assumes a 32-bit apb master and byte addresses of four times each index.
package ppi_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_PA_DATA = 8'h00;
  localparam logic [7:0] IDX_PB_DATA = 8'h01;
  localparam logic [7:0] IDX_PA_DIR = 8'h04;
  localparam logic [7:0] IDX_PB_DIR = 8'h05;
  localparam logic [7:0] IDX_IRQ_CSR = 8'h0A;
  localparam logic [7:0] IDX_PA_PULL = 8'h10;
  localparam logic [7:0] IDX_PB_PULL = 8'h11;
  localparam int ADDR_W = 8;

  // ==========================================================
  // field positions
  localparam int PB_SLOW_BIT = 7;
  localparam int CSR_IRQ_EN_BIT = 7;
  localparam int CSR_TOP_EN_BIT = 6;
  localparam int CSR_IRQ_FLAG_BIT = 3;
  localparam int CSR_TOP_FLAG_BIT = 2;
  localparam int CSR_IRQ_CLR_BIT = 1;
  localparam int CSR_TOP_CLR_BIT = 0;
  localparam int PA_W = 8;
  localparam int PB_W = 6;

  // ==========================================================
  // reset values
  localparam logic [7:0] PA_RST = 8'h00;
  localparam logic [5:0] PB_RST = 6'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ==========================================================
  // apb request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } ppi_apb_req_s;

endpackage

// [testbench/ppi_pin_model.sv]
// ppi_pin_model: outside loads on one port: a driver per line, pulls, floating lines.
// assumes the device gives out, active-low enable and pull per line; od marks open drain.
`timescale 1ns/100ps
`default_nettype none
module ppi_pin_model #(
  parameter int W = 8,
  parameter logic [W-1:0] OD = '0
) (
  input wire logic clk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oen_n,
  input wire logic [W-1:0] pull,
  input wire logic [W-1:0] ext,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin
);
  // ==========================================================
  // resolution
  logic [W-1:0] noise = '0;
  // a floating line wanders every cycle, so a stale level is never read back as good
  always @(posedge clk) begin
    noise <= ~noise;
  end
  // the device driver wins, then the outside driver, then the pull, else noise
  always_comb begin
    for (int k = 0; k < W; k++) begin
      if (!oen_n[k]) pin[k] = out[k];
      else if (ext_en[k]) pin[k] = ext[k];
      else if (pull[k]) pin[k] = OD[k]; // pull-up on open drain, else pull-down
      else pin[k] = noise[k];
    end
  end
endmodule // ppi_pin_model
`default_nettype wire

// [testbench/tb.sv]
// tb: self-checking bench for ppi_port_pins, random and corner cases over apb.
// assumes a zero-wait apb slave; all inputs change by non-blocking at the rising edge.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ppi_pkg::*;
  // ==========================================================
  // signals
  logic clk, rstn, irq_n, rpin_n, lvd, rst_wire, pready, pslverr, er, irq, tirq;
  logic rst_out, rst_oen_n, core_n, pb_slow, slow;
  ppi_apb_req_s req;
  logic [31:0] prdata, rd, seed;
  logic [7:0] pa_in, pa_out, pa_oen, pa_pull, pa_ext, pa_en, dira, lata, pap;
  logic [7:0] dirb, latb, pbp, pb_ext, pb_en;
  logic [5:0] pb_in, pb_out, pb_oen, pb_pull;
  logic [1:0] pa_slow;
  int err_count, n_compared, i;
  // the reset pin is pulled up outside and pulled low by the device when it drives
  assign rst_wire = rst_oen_n ? rpin_n : rst_out;
  ppi_port_pins DUT (.I_REF_CLK(clk), .I_RESETN(rstn), .I_APB(req), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PA_IN(pa_in), .O_PA_OUT(pa_out),
    .O_PA_OEN_N(pa_oen), .O_PA_PULL(pa_pull), .O_PA_SLOW(pa_slow), .I_PB_IN(pb_in),
    .O_PB_OUT(pb_out), .O_PB_OEN_N(pb_oen), .O_PB_PULL(pb_pull), .O_PB_SLOW(pb_slow),
    .I_IRQ_N(irq_n), .O_IRQ_REQ(irq), .O_TOP_IRQ_REQ(tirq), .I_RESET_PIN_N(rst_wire),
    .I_LOW_VOLTAGE_DETECTOR_RESET(lvd), .O_RESET_PIN_OUT(rst_out),
    .O_RESET_PIN_OEN_N(rst_oen_n), .O_CORE_RESET_N(core_n));
  ppi_pin_model #(.W(8), .OD(8'hC0)) pa_load (.clk(clk), .out(pa_out), .oen_n(pa_oen),
    .pull(pa_pull), .ext(pa_ext), .ext_en(pa_en), .pin(pa_in));
  ppi_pin_model #(.W(6), .OD(6'h06)) pb_load (.clk(clk), .out(pb_out), .oen_n(pb_oen),
    .pull(pb_pull), .ext(pb_ext[5:0]), .ext_en(pb_en[5:0]), .pin(pb_in));
  // ==========================================================
  // helpers
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // a line drives when it is an output and either push-pull or holding a low
  function automatic logic [7:0] exp_oen(input logic [7:0] d, l, od);
    return ~(d & (~od | ~l));
  endfunction
  function automatic logic [7:0] exp_pull(input logic [7:0] d, p, od);
    return p & (od | ~d);
  endfunction
  function automatic logic [31:0] exp_rd(input logic [7:0] d, l, p);
    return {24'h0, (d & l) | (~d & p)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    tally_and_finish();
  endtask
  // one apb transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) give_up();
    rd = prdata;
    er = pslverr;
    req <= '0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx << 2, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask
  // waits for the main request, or for the top line request when top is set
  task automatic wait_hi(input logic top);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if ((top ? tirq : irq) === 1'b1) break;
    end
    if (n == 20) give_up();
  endtask
  // ==========================================================
  // clock and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rstn = 0; irq_n = 1; rpin_n = 1; lvd = 0; req = '0; seed = 16;
    pa_ext = 0; pa_en = 8'hFF; pb_ext = 0; pb_en = 8'hFF; err_count = 0; n_compared = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("pa_oen_n", pa_oen, 8'hFF);
    chk("pb_oen_n", pb_oen, 6'h3F);
    rdchk("pa_dir", IDX_PA_DIR, 0);
    rdchk("pb_dir", IDX_PB_DIR, 0);
    // random direction, data and pull settings, slow on every other pass, with pin levels on inputs
    for (i = 0; i < 8; i++) begin
      dira = xs(); lata = xs(); pap = xs(); dirb = xs() & 8'h3F; pbp = xs() & 8'h3F;
      latb = xs() & 8'h39; slow = i[0];
      if (i == 0) dira = 8'hFF;
      latb[2:1] = {2{latb[0]}};
      pa_ext <= xs(); pb_ext <= xs() & 8'h3F; pa_en <= ~dira; pb_en <= ~dirb;
      apb(1'b1, IDX_PA_DIR << 2, {24'h0, dira});
      apb(1'b1, IDX_PA_DATA << 2, {24'h0, lata});
      apb(1'b1, IDX_PB_DIR << 2, {24'h0, slow, 1'b0, dirb[5:0]});
      apb(1'b1, IDX_PB_DATA << 2, {24'h0, latb});
      apb(1'b1, IDX_PA_PULL << 2, {24'h0, pap});
      apb(1'b1, IDX_PB_PULL << 2, {24'h0, pbp});
      repeat (2) @(posedge clk);
      #1;
      chk("pa_oen_n", pa_oen, exp_oen(dira, lata, 8'hC0));
      chk("pa_out", pa_out, {2'b00, lata[5:0]});
      chk("pb_oen_n", {2'b11, pb_oen}, exp_oen(dirb, latb, 8'h06));
      chk("pb_out", {2'b00, pb_out}, latb & 8'h39);
      chk("pa_pull", pa_pull, exp_pull(dira, pap, 8'hC0));
      chk("pb_pull", {2'b00, pb_pull}, exp_pull(dirb, pbp, 8'h06));
      chk("pa_slow", pa_slow, {2{slow}} & dira[7:6]);
      chk("pb_slow", pb_slow, slow & dirb[1]);
      rdchk("pa_data", IDX_PA_DATA, exp_rd(dira, lata, pa_ext));
      rdchk("pb_data", IDX_PB_DATA, exp_rd(dirb, latb, pb_ext));
      rdchk("pb_dir", IDX_PB_DIR, {24'h0, slow, 1'b0, dirb[5:0]});
    end
    // slow on: line two of port b follows one cycle behind line one
    apb(1'b1, IDX_PB_DIR << 2, 32'h0000_0086);
    apb(1'b1, IDX_PB_DATA << 2, 32'h0000_0000);
    repeat (3) @(posedge clk);
    apb(1'b1, IDX_PB_DATA << 2, 32'h0000_0006);
    @(posedge clk);
    #1;
    chk("pb1_oen_n", pb_oen[1], 1);
    chk("pb2_oen_n", pb_oen[2], 0);
    @(posedge clk);
    #1;
    chk("pb2_oen_n", pb_oen[2], 1);
    // unmapped and misaligned addresses are refused with read data zero
    apb(1'b0, 8'h08, 0);
    chk("pslverr", er, 1);
    chk("prdata", rd, RD_ZERO);
    apb(1'b1, 8'h41, 32'h0000_00FF);
    chk("pslverr", er, 1);
    rdchk("pa_pull", IDX_PA_PULL, {24'h0, pap});
    // main interrupt: pin edge, no re-trigger on a held low, then keypad lines
    pa_en <= 8'hFF;
    pa_ext <= 8'h80;
    apb(1'b1, IDX_PA_DIR << 2, 0);
    apb(1'b1, IDX_IRQ_CSR << 2, 32'h0000_0003);
    apb(1'b1, IDX_IRQ_CSR << 2, 32'h0000_00C0);
    rdchk("irq_csr", IDX_IRQ_CSR, 32'h0000_00C0);
    irq_n <= 1'b0;
    wait_hi(1'b0);
    apb(1'b1, IDX_IRQ_CSR << 2, 32'h0000_00C2);
    repeat (4) @(posedge clk);
    #1;
    chk("irq_req", irq, 0);
    @(posedge clk);
    irq_n <= 1'b1;
    // the pin must read high through its synchroniser first, else the keypad
    // rise merges into a request that never went away and no edge is seen
    repeat (4) @(posedge clk);
    pa_ext <= 8'h84;
    wait_hi(1'b0);
    rdchk("irq_csr", IDX_IRQ_CSR, 32'h0000_00C8);
    apb(1'b1, IDX_IRQ_CSR << 2, 32'h0000_00C2);
    repeat (4) @(posedge clk);
    #1;
    chk("irq_req", irq, 0);
    // top line falling edge raises its own request only
    @(posedge clk);
    pa_ext <= 8'h04;
    wait_hi(1'b1);
    rdchk("irq_csr", IDX_IRQ_CSR, 32'h0000_00C4);
    // low-voltage reset drives the reset pin, then the pin resets the registers
    apb(1'b1, IDX_PA_DIR << 2, 32'h0000_0055);
    @(posedge clk);
    lvd <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("rst_pin", {rst_oen_n, rst_out}, 0);
    @(posedge clk);
    lvd <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk("pa_dir", IDX_PA_DIR, 0);
    apb(1'b1, IDX_PA_DIR << 2, 32'h0000_0055);
    @(posedge clk);
    rpin_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("core_rst_n", core_n, 0);
    @(posedge clk);
    rpin_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk("pa_dir", IDX_PA_DIR, 0);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
